// [rtl/power_mode_manager.sv]
// Power mode manager: power-down pin, internal reset, global modes
// and per-port PHY power-down.
// Assumes host strobes come from logic on clk; pins are asynchronous.
//
// Overview of operation
// - Power-down pin low powers down whole chip
// - Pin release applies internal chip reset
// - Mode field: normal, energy, soft down, saving
// - Reset leaves mode field at normal
// - Normal: clocks, PHY, MAC, host all on
// - From normal, host may select any mode
// - Energy mode: idle beyond sleep delay sleeps
// - Asleep: only receiver energy detect stays on
// - Asleep: 120 ns pulse once per second
// - Energy seen while asleep returns to normal
// - Soft down: clocks, PHYs, MACs all off
// - Soft down: host access wakes with reset
// - Saving needs mode 11, autoneg, no cable
// - Saving: receiver off, back on with activity
// - From saving, host may select any mode
// - Port control bit powers down port PHY
// - Management control bit powers down PHY
`timescale 1ns/1ps
module power_mode_manager #(
  parameter int PULSE_PERIOD = power_mode_pkg::PULSE_PERIOD_CYC,
  parameter int SLEEP_UNIT = power_mode_pkg::SLEEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_power_down_n,
  input wire logic [power_mode_pkg::NUM_PORTS-1:0] cable_energy,
  input wire logic mode_wr,
  input wire logic [1:0] mode_sel,
  input wire logic [7:0] sleep_time,
  input wire logic host_access,
  input wire logic autoneg_en,
  input wire logic [power_mode_pkg::NUM_PORTS-1:0] port_ctrl_pd,
  input wire logic [power_mode_pkg::NUM_PORTS-1:0] miim_pd,
  output logic [1:0] power_mode,
  output logic chip_reset_n,
  output logic pll_clk_en,
  output logic mac_en,
  output logic host_if_en,
  output logic [power_mode_pkg::NUM_PORTS-1:0] phy_tx_en,
  output logic [power_mode_pkg::NUM_PORTS-1:0] phy_rx_en,
  output logic energy_detect_on,
  output logic low_power,
  output logic link_pulse
);
  localparam int NP = power_mode_pkg::NUM_PORTS;

  typedef enum logic [1:0] {ST_OFF, ST_RESET, ST_ACTIVE} top_t;

  typedef struct packed {
    top_t top;
    logic [1:0] mode;
    logic asleep;
    logic [7:0] sleep_count;
    logic [4:0] reset_count;
    logic [2:0] pulse_count;
    logic chip_reset_n;
    logic pll_clk_en;
    logic mac_en;
    logic host_if_en;
    logic [NP-1:0] phy_tx_en;
    logic [NP-1:0] phy_rx_en;
    logic energy_detect_on;
    logic link_pulse;
  } state_t;

  localparam state_t STATE_RESET = '{
    top: ST_OFF,
    mode: power_mode_pkg::MODE_RESET,
    default: '0
  };

  // Core logic runs whenever the mode keeps the clocks alive
  function automatic logic clocks_on(input logic [1:0] mode,
                                     input logic asleep);
    clocks_on = (mode == power_mode_pkg::MODE_NORMAL) ||
                (mode == power_mode_pkg::MODE_SAVING) ||
                (mode == power_mode_pkg::MODE_ENERGY && !asleep);
  endfunction

  state_t s;
  state_t next_s;

  logic [NP:0] pins_sync;
  logic pin_up;
  logic [NP-1:0] energy;
  logic any_energy;
  logic [NP-1:0] port_pd;
  logic [NP-1:0] rx_idle;

  tick_if sleep_tick ();
  tick_if pulse_tick ();

  pin_sync #(
    .WIDTH(NP + 1),
    .INIT({1'b1, {NP{1'b0}}})
  ) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({chip_power_down_n, cable_energy}),
    .level(pins_sync)
  );

  assign pin_up = pins_sync[NP];
  assign energy = pins_sync[NP-1:0];
  assign any_energy = |energy;

  tick_gen #(
    .PERIOD(SLEEP_UNIT)
  ) u_sleep_tick (
    .clk(clk),
    .resetn(resetn),
    .t(sleep_tick)
  );

  tick_gen #(
    .PERIOD(PULSE_PERIOD)
  ) u_pulse_tick (
    .clk(clk),
    .resetn(resetn),
    .t(pulse_tick)
  );

  // Sleep time base runs only while idle in energy detect mode
  assign sleep_tick.run = s.top == ST_ACTIVE && !s.asleep && !any_energy &&
                          s.mode == power_mode_pkg::MODE_ENERGY;
  assign pulse_tick.run = s.top == ST_ACTIVE && s.asleep;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      assign port_pd[gi] = port_ctrl_pd[gi] | miim_pd[gi];
      // Unused receiver idles while saving with no line activity
      assign rx_idle[gi] = autoneg_en && !energy[gi];
    end
  endgenerate

  always_comb begin
    next_s = s;
    case (s.top)
      ST_OFF: begin
        next_s.mode = power_mode_pkg::MODE_RESET;
        next_s.asleep = 1'b0;
        next_s.reset_count = '0;
        next_s.top = ST_RESET;
      end
      ST_RESET: begin
        next_s.mode = power_mode_pkg::MODE_RESET;
        next_s.asleep = 1'b0;
        next_s.sleep_count = '0;
        next_s.reset_count = s.reset_count + 1'b1;
        if (s.reset_count == power_mode_pkg::RESET_LAST) begin
          next_s.top = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (s.mode == power_mode_pkg::MODE_SOFT_DOWN) begin
          if (host_access) begin
            next_s.top = ST_RESET;
            next_s.mode = power_mode_pkg::MODE_RESET;
            next_s.reset_count = '0;
          end
        end else if (mode_wr && !s.asleep) begin
          next_s.mode = mode_sel;
          next_s.sleep_count = '0;
        end
        if (next_s.mode != power_mode_pkg::MODE_ENERGY) begin
          next_s.asleep = 1'b0;
          next_s.sleep_count = '0;
        end else if (s.asleep) begin
          if (any_energy) begin
            next_s.asleep = 1'b0;
            next_s.sleep_count = '0;
          end
        end else if (any_energy) begin
          next_s.sleep_count = '0;
        end else if (s.sleep_count >= sleep_time) begin
          next_s.asleep = 1'b1;
        end else if (sleep_tick.tick) begin
          next_s.sleep_count = s.sleep_count + 1'b1;
        end
      end
      default: begin
        next_s.top = ST_OFF;
      end
    endcase
    if (!pin_up) begin
      next_s.top = ST_OFF;
      next_s.mode = power_mode_pkg::MODE_RESET;
      next_s.asleep = 1'b0;
    end
    // Line pulse while asleep
    if (pulse_tick.tick && next_s.asleep) begin
      next_s.pulse_count = power_mode_pkg::PULSE_WIDTH_CYC;
    end else if (s.pulse_count != 3'h0) begin
      next_s.pulse_count = s.pulse_count - 1'b1;
    end
    // Outputs follow the next state so they change with it
    next_s.chip_reset_n = next_s.top == ST_ACTIVE;
    next_s.pll_clk_en = next_s.top == ST_ACTIVE &&
                        clocks_on(next_s.mode, next_s.asleep);
    next_s.mac_en = next_s.pll_clk_en;
    next_s.host_if_en = next_s.pll_clk_en;
    next_s.phy_tx_en = {NP{next_s.pll_clk_en}} & ~port_pd;
    next_s.phy_rx_en = next_s.phy_tx_en;
    if (next_s.mode == power_mode_pkg::MODE_SAVING) begin
      next_s.phy_rx_en = next_s.phy_tx_en & ~rx_idle;
    end
    next_s.energy_detect_on = next_s.top == ST_ACTIVE && next_s.asleep;
    next_s.link_pulse = next_s.pulse_count != 3'h0;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign power_mode = s.mode;
  assign chip_reset_n = s.chip_reset_n;
  assign pll_clk_en = s.pll_clk_en;
  assign mac_en = s.mac_en;
  assign host_if_en = s.host_if_en;
  assign phy_tx_en = s.phy_tx_en;
  assign phy_rx_en = s.phy_rx_en;
  assign energy_detect_on = s.energy_detect_on;
  assign low_power = s.asleep;
  assign link_pulse = s.link_pulse;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic active;
  assign active = s.top == ST_ACTIVE;

  // Pin seen low, then high
  sequence pin_released;
    !pin_up ##1 pin_up;
  endsequence

  // Pin stays high for the whole internal reset
  sequence pin_held;
    pin_up [*8] ##1 pin_up [*8];
  endsequence

  // Host access taken while in soft power down
  sequence soft_access;
    active && pin_up && host_access &&
    power_mode == power_mode_pkg::MODE_SOFT_DOWN;
  endsequence

  // Internal reset still applied, then lifted on the next cycle
  sequence reset_then_run;
    !chip_reset_n ##1 chip_reset_n;
  endsequence

  AST_PIN_DOWN_OFF: assert property (
    !pin_up |=> !pll_clk_en && !mac_en && phy_tx_en == '0 && !chip_reset_n)
    else $error("chip not off while power-down pin low");

  AST_RELEASE_RESET: assert property (
    pin_released ##1 pin_held |-> reset_then_run)
    else $error("no internal reset after pin release");

  AST_RESET_NORMAL: assert property (
    $rose(chip_reset_n) |-> power_mode == power_mode_pkg::MODE_NORMAL)
    else $error("mode not normal after reset");

  AST_NORMAL_ON: assert property (
    active && pin_up && !mode_wr &&
    power_mode == power_mode_pkg::MODE_NORMAL
    |=> pll_clk_en && mac_en && host_if_en)
    else $error("normal mode blocks not all on");

  AST_MODE_WRITE: assert property (
    active && pin_up && mode_wr &&
    (power_mode == power_mode_pkg::MODE_NORMAL ||
     power_mode == power_mode_pkg::MODE_SAVING)
    |=> power_mode == $past(mode_sel))
    else $error("mode write not taken");

  AST_SOFT_OFF: assert property (
    active && power_mode == power_mode_pkg::MODE_SOFT_DOWN && pin_up &&
    !host_access |=> !pll_clk_en && !mac_en && phy_tx_en == '0)
    else $error("soft power down left blocks on");

  AST_SLEEP_ENTRY: assert property (
    active && pin_up && !mode_wr && !low_power && !any_energy &&
    power_mode == power_mode_pkg::MODE_ENERGY && sleep_time == 8'h00
    |=> low_power ##0 !pll_clk_en)
    else $error("zero sleep delay did not sleep");

  AST_ASLEEP_STATE: assert property (
    low_power && active |-> energy_detect_on && !mac_en && !host_if_en)
    else $error("asleep with circuitry on");

  AST_PULSE_WIDTH: assert property (
    $rose(link_pulse) |-> link_pulse [*5] ##1 !link_pulse)
    else $error("line pulse width wrong");

  AST_WAKE_ENERGY: assert property (
    low_power && active && pin_up && any_energy |=> !low_power ##0 pll_clk_en)
    else $error("energy did not wake");

  AST_SOFT_WAKE: assert property (
    soft_access ##1 pin_held |-> reset_then_run)
    else $error("host access did not wake with reset");

  AST_SOFT_WAKE_MODE: assert property (
    soft_access |=> power_mode == power_mode_pkg::MODE_NORMAL && !chip_reset_n)
    else $error("soft wake did not restore normal mode");

  AST_PSAVE_RX: assert property (
    active && pin_up && !mode_wr && autoneg_en && !energy[0] &&
    power_mode == power_mode_pkg::MODE_SAVING
    |=> !phy_rx_en[0] && mac_en && host_if_en)
    else $error("saving mode receiver not off");

  AST_PORT_PD: assert property (
    ##1 1'b1 |-> ((phy_tx_en | phy_rx_en) & $past(port_pd)) == '0)
    else $error("powered-down port PHY enabled");

  AST_SLEEP_HOLD: assert property (
    active && pin_up && !mode_wr && !low_power && any_energy &&
    power_mode == power_mode_pkg::MODE_ENERGY |=> !low_power)
    else $error("slept while cable energy present");

  AST_SLEEP_WRITE_REFUSED: assert property (
    low_power && active && pin_up && mode_wr |=>
    power_mode == power_mode_pkg::MODE_ENERGY)
    else $error("mode write taken while asleep");

  AST_PULSE_ASLEEP: assert property (
    $rose(link_pulse) |-> low_power && energy_detect_on)
    else $error("line pulse started while awake");

  AST_RESET_QUIET: assert property (
    !chip_reset_n |-> !pll_clk_en && !mac_en && !host_if_en &&
    phy_tx_en == '0 && phy_rx_en == '0 && !energy_detect_on)
    else $error("blocks on during internal reset");

  AST_SAVING_TX: assert property (
    active && pin_up && !mode_wr && port_pd == '0 &&
    power_mode == power_mode_pkg::MODE_SAVING
    |=> phy_tx_en == '1 && pll_clk_en)
    else $error("saving mode transmitter off");
endmodule // power_mode_manager

// [rtl/power_mode_pkg.sv]
// Constants shared by the power mode manager and its helpers.
// Assumes a single 40 MHz clock.
package power_mode_pkg;
  localparam int NUM_PORTS = 5;
  localparam int CLK_FREQ_MHZ = 40;
  // Power mode field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_DOWN = 2'h2;
  localparam logic [1:0] MODE_SAVING = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_NORMAL;
  // Line pulse while asleep: 120 ns wide, once a second
  localparam int PULSE_WIDTH_NS = 120;
  localparam int PULSE_WIDTH_INT = (PULSE_WIDTH_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [2:0] PULSE_WIDTH_CYC = 3'(PULSE_WIDTH_INT);
  localparam int PULSE_PERIOD_MS = 1000;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_MS * CLK_FREQ_MHZ * 1000;
  // Time base of the sleep delay
  localparam int SLEEP_UNIT_US = 1000;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * CLK_FREQ_MHZ;
  // Internal chip reset length
  localparam int RESET_HOLD_CYC = 16;
  localparam logic [4:0] RESET_LAST = 5'(RESET_HOLD_CYC - 1);
  localparam int TICK_CNT_W = 26;
endpackage

// [rtl/tick_if.sv]
// Enable request and tick pulse between a divider and its user.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport user (output run, input tick);
endinterface

// [rtl/pin_sync.sv]
// Two flip-flop synchroniser for asynchronous pins.
// Assumes pins are quasi-static relative to clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;
  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s.meta = pin;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= {INIT, INIT};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.stable;
endmodule // pin_sync

// [rtl/tick_gen.sv]
// Divider giving a one-cycle enable pulse every PERIOD cycles while run.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
module tick_gen #(
  parameter int PERIOD = 2
) (
  input wire logic clk,
  input wire logic resetn,
  tick_if.gen t
);
  localparam int W = power_mode_pkg::TICK_CNT_W;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  typedef struct packed {
    logic [power_mode_pkg::TICK_CNT_W-1:0] count;
    logic tick;
  } div_t;
  div_t s;
  div_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!t.run) begin
      next_s.count = '0;
    end else if (s.count == LAST) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign t.tick = s.tick;
endmodule // tick_gen

// [verif/cable_line_model.sv]
// Far-side model: cable energy per port and a monitor of sleep line pulses.
// Assumes plugged is driven by the bench just after the clock edge.
`timescale 1ns/1ps
module cable_line_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [power_mode_pkg::NUM_PORTS-1:0] plugged,
  input wire logic link_pulse,
  output logic [power_mode_pkg::NUM_PORTS-1:0] cable_energy,
  output logic [7:0] pulse_cnt,
  output logic [7:0] last_width
);
  logic [7:0] run;
  // A plugged cable with an active partner shows energy, an open one none
  assign cable_energy = plugged;
  // Counts sleep line pulses and keeps the width of the last one
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run <= 8'h00;
      pulse_cnt <= 8'h00;
      last_width <= 8'h00;
    end else if (link_pulse) begin
      run <= run + 8'h01;
    end else if (run != 8'h00) begin
      last_width <= run;
      pulse_cnt <= pulse_cnt + 8'h01;
      run <= 8'h00;
    end
  end
endmodule // cable_line_model

// [verif/power_mode_manager_tb.sv]
// Testbench for power_mode_manager: reset, pin, modes, sleep, port power-down.
// Assumes the design package, its modules and cable_line_model are compiled first.
`timescale 1ns/1ps
module power_mode_manager_tb;
  localparam int NP = power_mode_pkg::NUM_PORTS;
  localparam int PP = 50;
  localparam int SU = 8;
  logic clk;
  logic resetn;
  logic chip_power_down_n;
  logic mode_wr;
  logic [1:0] mode_sel;
  logic [7:0] sleep_time;
  logic host_access;
  logic autoneg_en;
  logic [NP-1:0] port_ctrl_pd, miim_pd, plugged, cable_energy, phy_tx_en, phy_rx_en;
  logic [1:0] power_mode;
  logic chip_reset_n, pll_clk_en, mac_en, host_if_en;
  logic energy_detect_on, low_power, link_pulse;
  logic [7:0] pulse_cnt, last_width;
  int miscompares, n_checks, cycles, n;

  power_mode_manager #(.PULSE_PERIOD(PP), .SLEEP_UNIT(SU)) dut_u (
    .clk(clk), .resetn(resetn), .chip_power_down_n(chip_power_down_n),
    .cable_energy(cable_energy), .mode_wr(mode_wr), .mode_sel(mode_sel),
    .sleep_time(sleep_time), .host_access(host_access), .autoneg_en(autoneg_en),
    .port_ctrl_pd(port_ctrl_pd), .miim_pd(miim_pd), .power_mode(power_mode),
    .chip_reset_n(chip_reset_n), .pll_clk_en(pll_clk_en), .mac_en(mac_en),
    .host_if_en(host_if_en), .phy_tx_en(phy_tx_en), .phy_rx_en(phy_rx_en),
    .energy_detect_on(energy_detect_on), .low_power(low_power), .link_pulse(link_pulse)
  );

  cable_line_model line_u (
    .clk(clk), .resetn(resetn), .plugged(plugged), .link_pulse(link_pulse),
    .cable_energy(cable_energy), .pulse_cnt(pulse_cnt), .last_width(last_width)
  );

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  // Waits at most lim cycles for chip_reset_n (sel 0) or low_power to reach val
  task automatic wait_for(input int sel, input logic val, input int lim);
    n = 0;
    while (n < lim && (sel == 0 ? chip_reset_n : low_power) !== val) begin
      step(1);
      n++;
    end
  endtask

  task automatic write_mode(input logic [1:0] m);
    mode_sel = m;
    mode_wr = 1'b1;
    step(1);
    mode_wr = 1'b0;
    step(1);
  endtask

  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0;
    chip_power_down_n = 1'b1;
    mode_wr = 1'b0;
    mode_sel = 2'h0;
    sleep_time = 8'h00;
    host_access = 1'b0;
    autoneg_en = 1'b0;
    port_ctrl_pd = '0;
    miim_pd = '0;
    plugged = '1;
    step(8);
    resetn = 1'b1;
    wait_for(0, 1'b1, 40);
    check("reset done", 8'h01, 8'(chip_reset_n));
    check("reset mode", 8'h00, 8'(power_mode));
    check("normal on", 8'h1f, 8'({pll_clk_en, mac_en, host_if_en, &phy_tx_en, &phy_rx_en}));
    // Per-port power-down from both control bits
    port_ctrl_pd = 5'h02;
    miim_pd = 5'h08;
    step(2);
    check("port pd tx", 8'h15, 8'(phy_tx_en));
    check("port pd rx", 8'h15, 8'(phy_rx_en));
    port_ctrl_pd = '0;
    miim_pd = '0;
    // Power saving with only port 4 connected
    autoneg_en = 1'b1;
    plugged = 5'h10;
    write_mode(power_mode_pkg::MODE_SAVING);
    step(3);
    check("saving mode", 8'h03, 8'(power_mode));
    check("saving rx", 8'h10, 8'(phy_rx_en));
    check("saving tx", 8'h1f, 8'(phy_tx_en));
    check("saving on", 8'h07, 8'({pll_clk_en, mac_en, host_if_en}));
    plugged = '1;
    step(4);
    check("saving rx back", 8'h1f, 8'(phy_rx_en));
    write_mode(power_mode_pkg::MODE_ENERGY);
    check("from saving", 8'h01, 8'(power_mode));
    // Energy detect with zero delay, then sleep pulses and wake
    plugged = '0;
    wait_for(1, 1'b1, 8);
    check("sleep now", 8'h01, 8'(low_power));
    check("asleep", 8'h20, 8'({energy_detect_on, pll_clk_en, mac_en, host_if_en,
      |phy_tx_en, |phy_rx_en}));
    write_mode(power_mode_pkg::MODE_NORMAL);
    check("asleep refuses write", 8'h01, 8'(power_mode));
    step(2 * PP + 10);
    check("pulse width", 8'(power_mode_pkg::PULSE_WIDTH_CYC), last_width);
    check("pulse count", 8'h01, 8'(pulse_cnt >= 8'h02 && pulse_cnt <= 8'h03));
    plugged = 5'h04;
    wait_for(1, 1'b0, 8);
    check("wake", 8'h07, 8'({low_power, pll_clk_en, mac_en, host_if_en}));
    // Sleep delay of three time-base units
    sleep_time = 8'h03;
    plugged = '0;
    wait_for(1, 1'b1, 80);
    check("sleep delay", 8'h01, 8'(n > 2 * SU && n <= 4 * SU + 4));
    plugged = '1;
    wait_for(1, 1'b0, 8);
    // Soft power down, woken by a host access
    write_mode(power_mode_pkg::MODE_NORMAL);
    write_mode(power_mode_pkg::MODE_SOFT_DOWN);
    check("soft down", 8'h00, 8'({pll_clk_en, mac_en, host_if_en, |phy_tx_en, |phy_rx_en}));
    host_access = 1'b1;
    step(1);
    host_access = 1'b0;
    step(1);
    check("wake reset", 8'h00, 8'({chip_reset_n, power_mode}));
    wait_for(0, 1'b1, 24);
    check("wake length", 8'h01, 8'(n >= 14 && n <= 17));
    check("wake on", 8'h07, 8'({pll_clk_en, mac_en, host_if_en}));
    // Power-down pin from saving mode
    write_mode(power_mode_pkg::MODE_SAVING);
    chip_power_down_n = 1'b0;
    step(4);
    check("pin down", 8'h00, 8'({chip_reset_n, pll_clk_en, mac_en, host_if_en, |phy_tx_en}));
    chip_power_down_n = 1'b1;
    step(4);
    check("pin reset", 8'h00, 8'(chip_reset_n));
    wait_for(0, 1'b1, 30);
    check("pin resume", 8'h04, 8'({chip_reset_n, power_mode}));
    step(2);
    finish_test();
  end
endmodule // power_mode_manager_tb
